// file: rtl/motor_set_lock_source_select.sv
// Bank select, parameter write lock and command source forcing
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "motor_set_lock_defs.svh"

// Notes on behaviour
// R1: Terminal set to function 08 selects the second parameter bank.
// R2: Terminal set to function 17 selects the third parameter bank.
// R3: Both bank selects on: second bank wins.
// R4: Bank changes are held off while running, applied once stopped.
// R5: No bank indication; the controller tracks bank from its own inputs.
// R6: While running only run-adjustable parameters may be written.
// R7: Terminal set to function 15 is the soft lock input.
// R8: Mode 00: lock input on protects all but lock mode.
// R9: Mode 01: lock input on protects all but lock mode and frequencies.
// R10: Modes 02 and 03 ignore lock input and always protect.
// R11: Mode 10: writes allowed only through run-time access mode.
// R12: Terminal set to function 31 forces the operator panel.
// R13: Force off uses configured sources; panel force uses the panel.
// R14: Terminal set to function 51 forces the terminal block.
// R15: Terminal force takes both commands from the terminal block.
// R16: Source change while running cancels run and stops output.
// R17: Controller drops all run commands, then issues a fresh one.
// R18: Any function may sit on any of the eight terminals.
// R19: No bank select uses bank one; missing third copy uses bank one.
// R20: Panel force has priority over terminal force.
module motor_set_lock_source_select #(
   parameter int NUM_TERMINALS = 8
) (
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          reset_n,
   // Intelligent input terminals, asynchronous
   input  wire logic [NUM_TERMINALS-1:0]      term_in,
   // Control core status
   input  wire logic                          motor_running,
   input  wire logic                          run_cmd_any,
   // Parameter write check
   input  wire motor_set_lock_pkg::param_req_t param_req,
   output var  motor_set_lock_pkg::param_ans_t param_ans,
   // Active bank and command sources
   output var  motor_set_lock_pkg::bank_t     active_bank,
   output logic [7:0]                         freq_src,
   output logic [7:0]                         run_src,
   output logic                               output_stop,
   // Register port
   input  wire logic [`REG_ADDR_W-1:0]        reg_addr,
   input  wire logic [`REG_DATA_W-1:0]        reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic [`REG_DATA_W-1:0]             reg_rdata
);

   logic [NUM_TERMINALS-1:0]       term_meta;
   logic [NUM_TERMINALS-1:0]       term_sync;
   logic [NUM_TERMINALS-1:0][7:0]  term_func;
   logic [7:0]                     lock_mode_setting;
   logic [7:0]                     freq_source_setting;
   logic [7:0]                     run_source_setting;
   logic                           bank2_select;
   logic                           bank3_select;
   logic                           soft_lock_input;
   logic                           force_panel_input;
   logic                           force_terminal_input;
   motor_set_lock_pkg::bank_t      next_bank;
   logic [7:0]                     next_freq_src;
   logic [7:0]                     next_run_src;
   logic                           source_change;
   logic                           write_ok;
   logic [`REG_DATA_W-1:0]         status_word;

   // Any terminal holding the code and switched on
   function automatic logic func_on(
      input logic [NUM_TERMINALS-1:0]      levels,
      input logic [NUM_TERMINALS-1:0][7:0] funcs,
      input logic [7:0]                    code
   );
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_TERMINALS; i++) begin
         if (funcs[i] == code && levels[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : func_on

   // Write protection by lock mode, lock input and run state
   function automatic logic lock_allows(
      input logic [7:0]                     mode,
      input logic                           lock_in,
      input logic                           running,
      input motor_set_lock_pkg::param_req_t req
   );
      logic ok;
      ok = 1'b1;
      case (mode)
         `LOCK_ALL_BY_INPUT:  ok = !lock_in || req.is_lock_mode;  // R8
         `LOCK_FREQ_BY_INPUT: ok = !lock_in || req.is_lock_mode
                                   || req.is_freq_exempt;         // R9
         `LOCK_ALL_ALWAYS:    ok = req.is_lock_mode;              // R10
         `LOCK_FREQ_ALWAYS:   ok = req.is_lock_mode
                                   || req.is_freq_exempt;         // R10
         `LOCK_RUN_ACCESS:    ok = req.run_access;                // R11
         default:             ok = 1'b1;
      endcase
      // Lock mode stays writable except under mode 10, or while running if not run-adjustable
      if (running && !req.run_adjustable) begin
         ok = 1'b0;                                               // R6
      end
      return ok;
   endfunction : lock_allows

   // Terminals are switches from outside; two flops before any use
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         term_meta <= '0;
         term_sync <= '0;
      end else begin
         term_meta <= term_in;
         term_sync <= term_meta;
      end
   end

   // Functions decoded from whichever terminal carries them
   always_comb begin
      bank2_select = func_on(term_sync, term_func,
                             `FUNC_BANK2_SELECT);                 // R1 R18
      bank3_select = func_on(term_sync, term_func,
                             `FUNC_BANK3_SELECT);                 // R2 R18
      soft_lock_input = func_on(term_sync, term_func,
                                `FUNC_SOFT_LOCK);                 // R7 R18
      force_panel_input = func_on(term_sync, term_func,
                                  `FUNC_FORCE_PANEL);             // R12 R18
      force_terminal_input = func_on(term_sync, term_func,
                                     `FUNC_FORCE_TERMINAL);       // R14 R18
   end

   // Bank selection
   always_comb begin
      if (bank2_select) begin
         next_bank = motor_set_lock_pkg::BANK_SECOND;             // R1 R3
      end else if (bank3_select) begin
         next_bank = motor_set_lock_pkg::BANK_THIRD;              // R2
      end else begin
         next_bank = motor_set_lock_pkg::BANK_FIRST;              // R19
      end
   end

   // Bank only moves while stopped, so a running motor keeps its data
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         active_bank <= motor_set_lock_pkg::BANK_FIRST;
      end else if (!motor_running) begin
         active_bank <= next_bank;                                // R4
      end
   end

   // Effective command sources
   always_comb begin
      if (force_panel_input) begin
         next_freq_src = `SRC_PANEL;                              // R13 R20
         next_run_src  = `SRC_PANEL;                              // R13 R20
      end else if (force_terminal_input) begin
         next_freq_src = `SRC_TERMINAL;                           // R15
         next_run_src  = `SRC_TERMINAL;                           // R15
      end else begin
         next_freq_src = freq_source_setting;                     // R13
         next_run_src  = run_source_setting;                      // R13
      end
      source_change = (next_freq_src != freq_src)
                      || (next_run_src != run_src);
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         freq_src <= `SRC_RESET;
         run_src  <= `SRC_RESET;
      end else begin
         freq_src <= next_freq_src;
         run_src  <= next_run_src;
      end
   end

   // Stop holds until every run command is dropped, so no restart
   // happens on a command left standing at the new source
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         output_stop <= 1'b0;
      end else if (source_change && motor_running) begin
         output_stop <= 1'b1;                                     // R16
      end else if (!run_cmd_any) begin
         output_stop <= 1'b0;                                     // R17
      end
   end

   // Parameter write check, answered one cycle after the request
   always_comb begin
      write_ok = lock_allows(lock_mode_setting, soft_lock_input,
                             motor_running, param_req);
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         param_ans <= '0;
      end else begin
         param_ans.valid <= param_req.valid;
         param_ans.grant <= param_req.valid && write_ok;
         if (active_bank == motor_set_lock_pkg::BANK_THIRD
             && !param_req.has_bank3) begin
            param_ans.bank <= motor_set_lock_pkg::BANK_FIRST;     // R19
         end else begin
            param_ans.bank <= active_bank;
         end
      end
   end

   // Register writes
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_TERMINALS; i++) begin
            term_func[i] <= `FUNC_RESET_VALUE;
         end
         lock_mode_setting   <= `LOCK_MODE_RESET;
         freq_source_setting <= `SRC_RESET;
         run_source_setting  <= `SRC_RESET;
      end else if (reg_wr) begin
         for (int i = 0; i < NUM_TERMINALS; i++) begin
            if (reg_addr == `ADDR_TERM_FUNC_BASE + 8'(i)) begin
               term_func[i] <= reg_wdata;                         // R18
            end
         end
         case (reg_addr)
            `ADDR_LOCK_MODE:   lock_mode_setting   <= reg_wdata;
            `ADDR_FREQ_SOURCE: freq_source_setting <= reg_wdata;
            `ADDR_RUN_SOURCE:  run_source_setting  <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Status deliberately leaves the active bank out
   always_comb begin
      status_word = '0;
      status_word[`STAT_LOCK_IN]        = soft_lock_input;
      status_word[`STAT_FORCE_PANEL]    = force_panel_input;
      status_word[`STAT_FORCE_TERMINAL] = force_terminal_input;
      status_word[`STAT_OUTPUT_STOP]    = output_stop;
      status_word[`STAT_MOTOR_RUNNING]  = motor_running;
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         if (reg_addr <= `ADDR_TERM_FUNC_LAST) begin
            reg_rdata <= term_func[reg_addr[2:0]];
         end else begin
            case (reg_addr)
               `ADDR_LOCK_MODE:   reg_rdata <= lock_mode_setting;
               `ADDR_FREQ_SOURCE: reg_rdata <= freq_source_setting;
               `ADDR_RUN_SOURCE:  reg_rdata <= run_source_setting;
               `ADDR_STATUS:      reg_rdata <= status_word;
               default:           reg_rdata <= '0;
            endcase
         end
      end else begin
         reg_rdata <= '0;
      end
   end

   a_bank_held_running: assert property (  // R4
      @(posedge ref_clk) disable iff (!reset_n)
      $past(motor_running) |-> active_bank == $past(active_bank))
      else $error("Bank changed while motor running");

   a_bank2_priority: assert property (  // R3
      @(posedge ref_clk) disable iff (!reset_n)
      (bank2_select && !motor_running)
      |=> active_bank == motor_set_lock_pkg::BANK_SECOND)
      else $error("Second bank did not win");

   a_bank_first_idle: assert property (  // R19
      @(posedge ref_clk) disable iff (!reset_n)
      (!bank2_select && !bank3_select && !motor_running)
      |=> active_bank == motor_set_lock_pkg::BANK_FIRST)
      else $error("First bank not used when idle");

   a_panel_forced: assert property (  // R20
      @(posedge ref_clk) disable iff (!reset_n)
      force_panel_input |=> freq_src == `SRC_PANEL
                            && run_src == `SRC_PANEL)
      else $error("Panel force not applied");

   a_terminal_forced: assert property (  // R15
      @(posedge ref_clk) disable iff (!reset_n)
      (force_terminal_input && !force_panel_input)
      |=> freq_src == `SRC_TERMINAL && run_src == `SRC_TERMINAL)
      else $error("Terminal force not applied");

   a_stop_on_change: assert property (  // R16
      @(posedge ref_clk) disable iff (!reset_n)
      (motor_running && (next_run_src != run_src)) |=> output_stop)
      else $error("Source change did not stop output");

   a_lock_mode_02: assert property (  // R10
      @(posedge ref_clk) disable iff (!reset_n)
      (param_req.valid && lock_mode_setting == `LOCK_ALL_ALWAYS
       && !param_req.is_lock_mode) |=> param_ans.valid && !param_ans.grant)
      else $error("Mode 02 granted a protected write");

   a_lock_mode_00: assert property (  // R8
      @(posedge ref_clk) disable iff (!reset_n)
      (param_req.valid && lock_mode_setting == `LOCK_ALL_BY_INPUT
       && !soft_lock_input && !motor_running) |=> param_ans.grant)
      else $error("Mode 00 refused with lock off");

   a_run_adjust: assert property (  // R6
      @(posedge ref_clk) disable iff (!reset_n)
      (param_req.valid && motor_running && !param_req.run_adjustable)
      |=> !param_ans.grant)
      else $error("Run-time write to fixed parameter");

   a_bank3_select: assert property (  // R2
      @(posedge ref_clk) disable iff (!reset_n)
      (bank3_select && !bank2_select && !motor_running)
      |=> active_bank == motor_set_lock_pkg::BANK_THIRD)
      else $error("Third bank not selected");

   a_mode01_exempt: assert property (  // R9
      @(posedge ref_clk) disable iff (!reset_n)
      (param_req.valid && lock_mode_setting == `LOCK_FREQ_BY_INPUT
       && param_req.is_freq_exempt && !motor_running) |=> param_ans.grant)
      else $error("Mode 01 refused an exempt write");

   a_mode10_refuse: assert property (  // R11
      @(posedge ref_clk) disable iff (!reset_n)
      (param_req.valid && lock_mode_setting == `LOCK_RUN_ACCESS
       && !param_req.run_access) |=> !param_ans.grant)
      else $error("Mode 10 granted without run access");

   a_config_source: assert property (  // R13
      @(posedge ref_clk) disable iff (!reset_n)
      (!force_panel_input && !force_terminal_input)
      |=> freq_src == $past(freq_source_setting)
          && run_src == $past(run_source_setting))
      else $error("Configured source not followed");

   a_read_one_cycle: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      !$past(reg_rd) |-> reg_rdata == '0)
      else $error("Read data outside its cycle");

endmodule : motor_set_lock_source_select
`default_nettype wire

// file: rtl/motor_set_lock_defs.svh
// Constants for motor bank select, parameter lock and source forcing
`ifndef MOTOR_SET_LOCK_DEFS_SVH
`define MOTOR_SET_LOCK_DEFS_SVH

// Terminal function codes
`define FUNC_BANK2_SELECT    8'h08
`define FUNC_SOFT_LOCK       8'h15
`define FUNC_BANK3_SELECT    8'h17
`define FUNC_FORCE_PANEL     8'h31
`define FUNC_FORCE_TERMINAL  8'h51
`define FUNC_RESET_VALUE     8'h00

// Lock modes
`define LOCK_ALL_BY_INPUT    8'h00
`define LOCK_FREQ_BY_INPUT   8'h01
`define LOCK_ALL_ALWAYS      8'h02
`define LOCK_FREQ_ALWAYS     8'h03
`define LOCK_RUN_ACCESS      8'h10
`define LOCK_MODE_RESET      8'h00

// Command source codes
`define SRC_TERMINAL         8'h01
`define SRC_PANEL            8'h02
`define SRC_RESET            8'h02

// Register map, byte addresses
`define REG_ADDR_W           8
`define REG_DATA_W           8
`define ADDR_TERM_FUNC_BASE  8'h00
`define ADDR_TERM_FUNC_LAST  8'h07
`define ADDR_LOCK_MODE       8'h08
`define ADDR_FREQ_SOURCE     8'h09
`define ADDR_RUN_SOURCE      8'h0A
`define ADDR_STATUS          8'h0B

// Status field positions
`define STAT_LOCK_IN         0
`define STAT_FORCE_PANEL     1
`define STAT_FORCE_TERMINAL  2
`define STAT_OUTPUT_STOP     3
`define STAT_MOTOR_RUNNING   4

`endif

// file: rtl/motor_set_lock_pkg.sv
// Types for motor bank select, parameter lock and source forcing
package motor_set_lock_pkg;

   typedef enum logic [1:0] {
      BANK_FIRST,
      BANK_SECOND,
      BANK_THIRD
   } bank_t;

   // Parameter write request from the control core
   typedef struct packed {
      logic valid;
      logic is_lock_mode;
      logic is_freq_exempt;
      logic run_adjustable;
      logic has_bank3;
      logic run_access;
   } param_req_t;

   // Answer to a parameter write request
   typedef struct packed {
      logic  valid;
      logic  grant;
      bank_t bank;
   } param_ans_t;

endpackage : motor_set_lock_pkg

// file: tb/terminal_side.sv
// Far-side model: terminal switches, run command sources, motor state
`timescale 1ns/100ps
`default_nettype none
module terminal_side (
   // Clock
   input  wire logic       ref_clk,
   // Levels wanted by the test sequence
   input  wire logic [7:0] want_pins,
   input  wire logic       want_run,
   input  wire logic       want_motor,
   // Terminal pins and core status
   output logic [7:0]      term_in,
   output logic            run_cmd_any,
   output logic            motor_running
);
   initial begin
      term_in       = 8'h00;
      run_cmd_any   = 1'b0;
      motor_running = 1'b0;
   end
   // Switch levels move only just after an edge, never mid-cycle
   always @(posedge ref_clk) begin
      term_in       <= want_pins;
      motor_running <= want_motor;
      // Run level copied as wanted; the test sequence drops it before any fresh run
      run_cmd_any   <= want_run;
   end
endmodule : terminal_side
`default_nettype wire

// file: tb/tb_motor_set_lock_source_select.sv
// Testbench for bank select, parameter lock and source forcing
`timescale 1ns/100ps
`default_nettype none
`include "motor_set_lock_defs.svh"
module tb_motor_set_lock_source_select;
   logic                            ref_clk = 1'b0;
   logic                            reset_n = 1'b0;
   logic [7:0]                      pins = 8'h00;
   logic                            run = 1'b0;
   logic                            motor = 1'b0;
   logic [7:0]                      term_in;
   logic                            run_cmd_any;
   logic                            motor_running;
   motor_set_lock_pkg::param_req_t  preq = '0;
   motor_set_lock_pkg::param_ans_t  pans;
   motor_set_lock_pkg::bank_t       bank;
   logic [7:0]                      fsrc;
   logic [7:0]                      rsrc;
   logic                            ostop;
   logic [7:0]                      raddr = 8'h00;
   logic [7:0]                      wdata = 8'h00;
   logic                            wr = 1'b0;
   logic                            rd = 1'b0;
   logic [7:0]                      rdata;
   int                              n_mismatch = 0;
   int                              comparisons = 0;
   int                              cycles = 0;
   logic [7:0]                      modes [5] = '{8'h00, 8'h01, 8'h02,
                                                  8'h03, 8'h10};

   always #12.5 ref_clk = ~ref_clk;

   terminal_side i_terminal_side (
      .ref_clk(ref_clk), .want_pins(pins), .want_run(run),
      .want_motor(motor), .term_in(term_in), .run_cmd_any(run_cmd_any),
      .motor_running(motor_running));

   motor_set_lock_source_select i_motor_set_lock_source_select (
      .ref_clk(ref_clk), .reset_n(reset_n), .term_in(term_in),
      .motor_running(motor_running), .run_cmd_any(run_cmd_any),
      .param_req(preq), .param_ans(pans), .active_bank(bank),
      .freq_src(fsrc), .run_src(rsrc), .output_stop(ostop),
      .reg_addr(raddr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata));

   task automatic give_verdict;
      if (n_mismatch == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got,
                  exp);
      end
   endtask : check

   task automatic check_bank(input logic [1:0] exp);
      check({6'h00, bank}, {6'h00, exp});
   endtask : check_bank

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      raddr <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      raddr <= a;
      rd    <= 1'b1;
      @(posedge ref_clk);
      rd    <= 1'b0;
      @(negedge ref_clk);
      check(rdata, exp);
   endtask : reg_read

   // Pins pass the far side, two sync flops and one register
   task automatic put(input logic [7:0] p, input logic m, input logic r);
      @(posedge ref_clk);
      pins  <= p;
      motor <= m;
      run   <= r;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : put

   task automatic pcheck(input logic [5:0] r, input logic g,
                         input logic [1:0] b);
      @(posedge ref_clk);
      preq <= r;
      @(posedge ref_clk);
      preq <= '0;
      @(negedge ref_clk);
      check({4'h0, pans}, {4'h0, 1'b1, g, b});
   endtask : pcheck

   task automatic srcs(input logic [7:0] p, input logic [7:0] e);
      put(p, 1'b0, 1'b0);
      check(fsrc, e);
      check(rsrc, e);
   endtask : srcs

   function automatic logic want_grant(input logic [7:0] m,
      input logic li, input logic lk, input logic fq, input logic ra);
      case (m)
         8'h00:   return !li || lk;
         8'h01:   return !li || lk || fq;
         8'h02:   return lk;
         8'h03:   return lk || fq;
         default: return ra;
      endcase
   endfunction : want_grant

   // Hang guard: whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
      check_bank(2'h0);
      check(fsrc, `SRC_RESET);
      check({7'h00, ostop}, 8'h00);
      reg_read(`ADDR_LOCK_MODE, 8'h00);
      reg_read(`ADDR_RUN_SOURCE, 8'h02);
      reg_read(8'h30, 8'h00);
      // Functions spread over unrelated terminals
      reg_write(8'h00, `FUNC_BANK2_SELECT);
      reg_write(8'h05, `FUNC_BANK3_SELECT);
      reg_write(8'h03, `FUNC_SOFT_LOCK);
      reg_write(8'h06, `FUNC_FORCE_PANEL);
      reg_write(8'h01, `FUNC_FORCE_TERMINAL);
      reg_read(8'h05, 8'h17);
      reg_write(`ADDR_STATUS, 8'hFF);
      reg_read(`ADDR_STATUS, 8'h00);
      // Controller tracks the bank from its own pin levels
      for (int i = 0; i < 4; i++) begin
         put({2'h0, i[1], 4'h0, i[0]}, 1'b0, 1'b0);
         check_bank(i == 0 ? 2'h0 : (i == 2 ? 2'h2 : 2'h1));
      end
      put(8'h21, 1'b1, 1'b0);
      put(8'h20, 1'b1, 1'b0);
      check_bank(2'h1);
      put(8'h20, 1'b0, 1'b0);
      check_bank(2'h2);
      pcheck(6'b100100, 1'b1, 2'h0);
      pcheck(6'b100110, 1'b1, 2'h2);
      put(8'h00, 1'b0, 1'b0);
      foreach (modes[i]) begin
         reg_write(`ADDR_LOCK_MODE, modes[i]);
         for (int li = 0; li < 2; li++) begin
            put({4'h0, li[0], 3'h0}, 1'b0, 1'b0);
            for (int k = 0; k < 4; k++) begin
               pcheck({1'b1, k == 1, k == 2, 2'b11, k == 3},
                      want_grant(modes[i], li[0], k == 1, k == 2, k == 3),
                      2'h0);
            end
         end
      end
      reg_write(`ADDR_LOCK_MODE, 8'h00);
      put(8'h00, 1'b1, 1'b0);
      pcheck(6'b100010, 1'b0, 2'h0);
      pcheck(6'b100110, 1'b1, 2'h0);
      srcs(8'h00, 8'h02);
      srcs(8'h02, 8'h01);
      srcs(8'h42, 8'h02);
      reg_write(`ADDR_FREQ_SOURCE, `SRC_TERMINAL);
      reg_write(`ADDR_RUN_SOURCE, `SRC_TERMINAL);
      srcs(8'h40, 8'h02);
      reg_read(`ADDR_STATUS, 8'h02);
      srcs(8'h00, 8'h01);
      // Source flip under a running motor must stop the output
      put(8'h00, 1'b1, 1'b1);
      check({7'h00, ostop}, 8'h00);
      put(8'h40, 1'b1, 1'b1);
      check({7'h00, ostop}, 8'h01);
      reg_read(`ADDR_STATUS, 8'h1A);
      put(8'h40, 1'b1, 1'b0);
      check({7'h00, ostop}, 8'h00);
      put(8'h40, 1'b1, 1'b1);
      check({7'h00, ostop}, 8'h00);
      put(8'h00, 1'b0, 1'b0);
      give_verdict();
   end
endmodule : tb_motor_set_lock_source_select
`default_nettype wire
